/* File: rtl/phs_pkg.sv */
// constants, register map and state types for the holdover and sync control block
package phs_pkg;
    localparam logic [3:0] ADDR_SYNC_CTRL = 4'h0;
    localparam logic [3:0] ADDR_HOLD_CTRL = 4'h1;
    localparam logic [3:0] ADDR_DAC_MAN = 4'h2;
    localparam logic [3:0] ADDR_DAC_TRIP = 4'h3;
    localparam logic [3:0] ADDR_LOOP1_LOCK = 4'h4;
    localparam logic [3:0] ADDR_LOOP2_LOCK = 4'h5;
    localparam logic [3:0] ADDR_DAC_DIV = 4'h6;
    localparam logic [3:0] ADDR_REF_CTRL = 4'h7;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_CFG_LAST = 4'h5;
    localparam int PAIRS = 6;
    localparam int DAC_W = 10;
    localparam int CNT_W = 14;
    localparam logic [DAC_W-1:0] DAC_MID = 10'h200;
    localparam logic [DAC_W-1:0] DAC_FULL = 10'h3ff;
    localparam logic [DAC_W-1:0] DAC_STEP_50MV = 10'h00f;
    localparam logic [13:0] CNT_RST = 14'h0000;
    localparam logic [9:0] DIV_RST = 10'h0001;
    localparam logic [15:0] SYNC_CTRL_RST = 16'h0000;
    localparam logic [2:0] POLICY_PIN_SEL = 3'h3;
    localparam logic [2:0] POLICY_AUTO4 = 3'h4;
    localparam logic [2:0] POLICY_AUTO6 = 3'h6;
    typedef enum logic [2:0] {
        HS_RUN = 3'b001,
        HS_HOLD = 3'b010,
        HS_EXIT = 3'b100
    } phs_hstate_t;
endpackage : phs_pkg

/* File: rtl/phs_ctrl.sv */
// holdover, lock detect, dac and output synchronization control
`timescale 1ns/1ps
`default_nettype none
module phs_ctrl (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic sync_pin,
    input wire logic loop1_pd_tick,
    input wire logic [7:0] loop1_phase_err,
    input wire logic loop2_pd_tick,
    input wire logic [7:0] loop2_phase_err,
    input wire logic [9:0] loop1_tune_level,
    input wire logic ref_loss,
    input wire logic [1:0] ref_sel_pins,
    input wire logic [1:0] ref_clk_tick,
    output logic [1:0] ref_sel_sensed,
    output logic [1:0] ref_div_tick,
    output logic [5:0] pair_in_sync,
    output logic loop1_lock,
    output logic loop2_lock,
    output logic holdover_active,
    output logic dac_on,
    output logic [9:0] dac_level,
    output logic dac_update,
    output logic clock_switch
);
    typedef struct packed {
        logic [15:0] sync_ctrl;
        logic [15:0] hold_ctrl;
        logic [9:0] dac_manual_value;
        logic [15:0] dac_trip;
        logic [15:0] loop1_cfg;
        logic [15:0] loop2_cfg;
        logic [9:0] dac_div;
        logic [15:0] ref_cfg;
        logic [15:0] rdata;
        logic sync_in_q;
        logic pol_q;
        logic [5:0] pair_sync;
        logic [13:0] loop1_cnt;
        logic [13:0] loop2_cnt;
        logic [13:0] hold_cnt;
        logic l1_lock;
        logic l2_lock;
        logic [9:0] div_cnt;
        logic dac_tick;
        logic [9:0] dac;
        logic dac_pwr;
        logic sw_evt;
        phs_pkg::phs_hstate_t hst;
        logic [1:0] sel_sensed;
        logic [7:0] pre_cnt0;
        logic [7:0] pre_cnt1;
        logic [1:0] pre_tick;
    } phs_state_t;

    phs_state_t st_reg;
    phs_state_t st_next;

    // sync_ctrl fields
    logic sync_polarity_invert;
    logic sync_hold_until_loop1_lock;
    logic sync_hold_until_loop2_lock;
    logic [5:0] pair_sync_exclude;
    logic qualified_dynamic_delay;
    logic sync_enable;
    logic sync_auto;
    // hold_ctrl, dac_trip, loop lock and ref_cfg fields, then internal nets
    logic holdover_enable;
    logic holdover_force;
    logic dac_track_enable;
    logic tune_rail_detect_enable;
    logic dac_manual_enable;
    logic [2:0] ref_select_policy;
    logic [13:0] holdover_exit_count;
    logic [5:0] dac_low_threshold;
    logic [5:0] dac_high_threshold;
    logic [7:0] loop1_lock_window;
    logic [7:0] loop2_lock_window;
    logic [13:0] loop1_lock_count;
    logic [13:0] loop2_lock_count;
    logic ref_select_pin_invert;
    logic [7:0] ref_input_prescaler [2];
    logic sync_raw;
    logic sync_fire;
    logic sync_hold;
    logic rail_low;
    logic rail_high;
    logic low_thr_hit;
    logic high_thr_hit;
    logic cfg_write;

    assign sync_polarity_invert = st_reg.sync_ctrl[0];
    assign sync_hold_until_loop1_lock = st_reg.sync_ctrl[1];
    assign sync_hold_until_loop2_lock = st_reg.sync_ctrl[2];
    assign pair_sync_exclude = st_reg.sync_ctrl[8:3];
    assign qualified_dynamic_delay = st_reg.sync_ctrl[9];
    assign sync_enable = st_reg.sync_ctrl[10];
    assign sync_auto = st_reg.sync_ctrl[11];
    assign holdover_enable = st_reg.hold_ctrl[0];
    assign holdover_force = st_reg.hold_ctrl[1];
    assign dac_track_enable = st_reg.hold_ctrl[2];
    assign tune_rail_detect_enable = st_reg.hold_ctrl[3];
    assign dac_manual_enable = st_reg.hold_ctrl[4];
    assign ref_select_policy = st_reg.hold_ctrl[7:5];
    assign holdover_exit_count = {6'h00, st_reg.hold_ctrl[15:8]};
    assign dac_low_threshold = st_reg.dac_trip[5:0];
    assign dac_high_threshold = st_reg.dac_trip[13:8];
    assign loop1_lock_window = st_reg.loop1_cfg[7:0];
    assign loop1_lock_count = {6'h00, st_reg.loop1_cfg[15:8]};
    assign loop2_lock_window = st_reg.loop2_cfg[7:0];
    assign loop2_lock_count = {6'h00, st_reg.loop2_cfg[15:8]};
    assign ref_select_pin_invert = st_reg.ref_cfg[0];
    assign ref_input_prescaler[0] = {1'b0, st_reg.ref_cfg[7:1]};
    assign ref_input_prescaler[1] = st_reg.ref_cfg[15:8];

    // qualified delay mode relies on software holding sync enable set
    assign sync_raw = sync_pin ^ sync_polarity_invert;
    assign cfg_write = reg_wr && (reg_addr <= phs_pkg::ADDR_CFG_LAST);
    // thresholds are 50mV steps from ground and from the supply rail
    assign low_thr_hit = {4'h0, st_reg.dac} <= (16'(dac_low_threshold) * 16'(phs_pkg::DAC_STEP_50MV));
    assign high_thr_hit = {4'h0, phs_pkg::DAC_FULL - st_reg.dac}
        <= (16'(dac_high_threshold) * 16'(phs_pkg::DAC_STEP_50MV));
    // rail detect is only meaningful in manual dac with auto policy 4/6
    assign rail_low = tune_rail_detect_enable && low_thr_hit;
    assign rail_high = tune_rail_detect_enable && high_thr_hit;

    always_comb begin
        st_next = st_reg;
        st_next.dac_tick = 1'b0;
        st_next.sw_evt = 1'b0;
        st_next.pre_tick = 2'b00;
        if (reg_wr) begin
            case (reg_addr)
                phs_pkg::ADDR_SYNC_CTRL: st_next.sync_ctrl = reg_wdata;
                phs_pkg::ADDR_HOLD_CTRL: st_next.hold_ctrl = reg_wdata;
                phs_pkg::ADDR_DAC_MAN: st_next.dac_manual_value = reg_wdata[9:0];
                phs_pkg::ADDR_DAC_TRIP: st_next.dac_trip = reg_wdata;
                phs_pkg::ADDR_LOOP1_LOCK: st_next.loop1_cfg = reg_wdata;
                phs_pkg::ADDR_LOOP2_LOCK: st_next.loop2_cfg = reg_wdata;
                phs_pkg::ADDR_DAC_DIV: st_next.dac_div = reg_wdata[9:0];
                phs_pkg::ADDR_REF_CTRL: st_next.ref_cfg = reg_wdata;
                default: ;
            endcase
        end
        st_next.rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                phs_pkg::ADDR_SYNC_CTRL: st_next.rdata = st_reg.sync_ctrl;
                phs_pkg::ADDR_HOLD_CTRL: st_next.rdata = st_reg.hold_ctrl;
                phs_pkg::ADDR_DAC_MAN: st_next.rdata = {6'h00, st_reg.dac};
                phs_pkg::ADDR_DAC_TRIP: st_next.rdata = st_reg.dac_trip;
                phs_pkg::ADDR_LOOP1_LOCK: st_next.rdata = st_reg.loop1_cfg;
                phs_pkg::ADDR_LOOP2_LOCK: st_next.rdata = st_reg.loop2_cfg;
                phs_pkg::ADDR_DAC_DIV: st_next.rdata = {6'h00, st_reg.dac_div};
                phs_pkg::ADDR_REF_CTRL: st_next.rdata = st_reg.ref_cfg;
                phs_pkg::ADDR_STATUS: st_next.rdata = {10'h000, st_reg.sw_evt, st_reg.dac_pwr,
                    st_reg.hst == phs_pkg::HS_HOLD, st_reg.l2_lock, st_reg.l1_lock, 1'b0};
                default: st_next.rdata = 16'h0000;
            endcase
        end
        // sync: pin edge, invert-bit toggle or auto sync on config write
        st_next.sync_in_q = sync_raw;
        st_next.pol_q = sync_polarity_invert;
        sync_fire = (sync_raw && !st_reg.sync_in_q && sync_enable)
            || (sync_polarity_invert != st_reg.pol_q)
            || (sync_auto && cfg_write);
        // enable rising edge intentionally not decoded as a trigger
        sync_hold = (sync_hold_until_loop1_lock && !st_reg.l1_lock)
            || (sync_hold_until_loop2_lock && !st_reg.l2_lock);
        for (int p = 0; p < phs_pkg::PAIRS; p++) begin
            if (pair_sync_exclude[p]) begin
                st_next.pair_sync[p] = 1'b0;
            end else if (sync_fire) begin
                st_next.pair_sync[p] = 1'b1;
            end else if (!sync_hold) begin
                st_next.pair_sync[p] = 1'b0;
            end
        end
        // lock counters saturate so lock stays set while in window
        if (loop1_pd_tick) begin
            if (loop1_phase_err < loop1_lock_window) begin
                if (st_reg.loop1_cnt != 14'h3fff) begin
                    st_next.loop1_cnt = st_reg.loop1_cnt + 14'h0001;
                end
            end else begin
                st_next.loop1_cnt = phs_pkg::CNT_RST;
            end
        end
        st_next.l1_lock = (st_next.loop1_cnt >= loop1_lock_count)
            && (st_next.loop1_cnt != phs_pkg::CNT_RST);
        if (loop2_pd_tick) begin
            if (loop2_phase_err < loop2_lock_window) begin
                if (st_reg.loop2_cnt != 14'h3fff) begin
                    st_next.loop2_cnt = st_reg.loop2_cnt + 14'h0001;
                end
            end else begin
                st_next.loop2_cnt = phs_pkg::CNT_RST;
            end
        end
        st_next.l2_lock = (st_next.loop2_cnt >= loop2_lock_count)
            && (st_next.loop2_cnt != phs_pkg::CNT_RST);
        // dac update divider runs on loop1 detector ticks
        if (loop1_pd_tick) begin
            if (st_reg.div_cnt + 10'h001 >= st_reg.dac_div) begin
                st_next.div_cnt = 10'h000;
                st_next.dac_tick = 1'b1;
            end else begin
                st_next.div_cnt = st_reg.div_cnt + 10'h001;
            end
        end
        if (st_reg.dac_tick) begin
            if (st_reg.hst == phs_pkg::HS_HOLD && dac_manual_enable) begin
                st_next.dac = st_reg.dac_manual_value;
            end else if (st_reg.hst != phs_pkg::HS_HOLD && dac_track_enable) begin
                st_next.dac = loop1_tune_level;
            end
        end
        st_next.sw_evt = rail_low || rail_high;
        case (st_reg.hst)
            phs_pkg::HS_RUN: begin
                if (holdover_force
                    || (holdover_enable && (ref_loss || st_reg.sw_evt))) begin
                    st_next.hst = phs_pkg::HS_HOLD;
                    st_next.hold_cnt = phs_pkg::CNT_RST;
                end
            end
            phs_pkg::HS_HOLD: begin
                if (loop1_pd_tick) begin
                    if (loop1_phase_err < loop1_lock_window) begin
                        st_next.hold_cnt = st_reg.hold_cnt + 14'h0001;
                    end else begin
                        st_next.hold_cnt = phs_pkg::CNT_RST;
                    end
                end
                if (!holdover_force && !ref_loss && !st_reg.sw_evt
                    && st_reg.hold_cnt >= holdover_exit_count) begin
                    st_next.hst = phs_pkg::HS_EXIT;
                end
            end
            phs_pkg::HS_EXIT: st_next.hst = phs_pkg::HS_RUN;
            default: st_next.hst = phs_pkg::HS_RUN;
        endcase
        st_next.dac_pwr = holdover_force || dac_track_enable
            || st_next.hst == phs_pkg::HS_HOLD;
        st_next.sel_sensed = (ref_select_policy == phs_pkg::POLICY_PIN_SEL
            || ref_select_policy == phs_pkg::POLICY_AUTO6) && ref_select_pin_invert
            ? ~ref_sel_pins : ref_sel_pins;
        // per-input prescalers; common divider sits downstream
        if (ref_clk_tick[0]) begin
            if (st_reg.pre_cnt0 + 8'h01 >= ref_input_prescaler[0]) begin
                st_next.pre_cnt0 = 8'h00;
                st_next.pre_tick[0] = 1'b1;
            end else begin
                st_next.pre_cnt0 = st_reg.pre_cnt0 + 8'h01;
            end
        end
        if (ref_clk_tick[1]) begin
            if (st_reg.pre_cnt1 + 8'h01 >= ref_input_prescaler[1]) begin
                st_next.pre_cnt1 = 8'h00;
                st_next.pre_tick[1] = 1'b1;
            end else begin
                st_next.pre_cnt1 = st_reg.pre_cnt1 + 8'h01;
            end
        end
        // vco cal and fast detector settings are software-kept
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.sync_ctrl <= phs_pkg::SYNC_CTRL_RST;
            st_reg.dac <= phs_pkg::DAC_MID;
            st_reg.dac_div <= phs_pkg::DIV_RST;
            st_reg.hst <= phs_pkg::HS_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign ref_sel_sensed = st_reg.sel_sensed;
    assign ref_div_tick = st_reg.pre_tick;
    assign pair_in_sync = st_reg.pair_sync;
    assign loop1_lock = st_reg.l1_lock;
    assign loop2_lock = st_reg.l2_lock;
    assign holdover_active = st_reg.hst == phs_pkg::HS_HOLD;
    assign dac_on = st_reg.dac_pwr;
    assign dac_level = st_reg.dac;
    assign dac_update = st_reg.dac_tick;
    assign clock_switch = st_reg.sw_evt;

    sequence s_force_written;
        reg_wr && reg_addr == phs_pkg::ADDR_HOLD_CTRL && reg_wdata[1];
    endsequence
    property p_force_hold;
        @(posedge core_clk) disable iff (sys_rst) s_force_written |-> ##2 holdover_active ##0 dac_on;
    endproperty
    a_force_hold: assert property (p_force_hold) else $error("forced holdover not taken");
    property p_excl;
        @(posedge core_clk) disable iff (sys_rst) (pair_sync_exclude[0]) |=> !pair_in_sync[0];
    endproperty
    a_excl: assert property (p_excl) else $error("excluded pair was synced");
    property p_auto_sync;
        @(posedge core_clk) disable iff (sys_rst)
            (sync_auto && cfg_write && pair_sync_exclude == 6'h00 && !reg_addr[0] && reg_addr != 4'h0)
            |=> pair_in_sync == 6'h3f;
    endproperty
    a_auto_sync: assert property (p_auto_sync) else $error("auto sync missing");
    property p_pol_toggle;
        @(posedge core_clk) disable iff (sys_rst)
            (sync_polarity_invert != $past(sync_polarity_invert) && pair_sync_exclude[1] == 1'b0
             && $past(pair_sync_exclude[1]) == 1'b0) |=> pair_in_sync[1];
    endproperty
    a_pol_toggle: assert property (p_pol_toggle) else $error("polarity toggle did not sync");
    property p_l1_drop;
        @(posedge core_clk) disable iff (sys_rst)
            (loop1_pd_tick && loop1_phase_err >= loop1_lock_window) |=> !loop1_lock;
    endproperty
    a_l1_drop: assert property (p_l1_drop) else $error("loop1 lock kept after error");
    property p_l2_drop;
        @(posedge core_clk) disable iff (sys_rst)
            (loop2_pd_tick && loop2_phase_err >= loop2_lock_window) |=> !loop2_lock;
    endproperty
    a_l2_drop: assert property (p_l2_drop) else $error("loop2 lock kept after error");
    property p_l1_need_cnt;
        @(posedge core_clk) disable iff (sys_rst) loop1_lock |-> st_reg.loop1_cnt >= loop1_lock_count;
    endproperty
    a_l1_need_cnt: assert property (p_l1_need_cnt) else $error("loop1 lock early");
    property p_manual;
        @(posedge core_clk) disable iff (sys_rst)
            (dac_update && holdover_active && dac_manual_enable) |=> dac_level == $past(st_reg.dac_manual_value);
    endproperty
    a_manual: assert property (p_manual) else $error("manual dac not applied");
    property p_rail_low;
        @(posedge core_clk) disable iff (sys_rst) rail_low |=> clock_switch;
    endproperty
    a_rail_low: assert property (p_rail_low) else $error("low rail switch missing");
    property p_hold_exit;
        @(posedge core_clk) disable iff (sys_rst)
            (holdover_active && !$past(holdover_active)) |-> st_reg.hold_cnt == 14'h0000;
    endproperty
    a_hold_exit: assert property (p_hold_exit) else $error("holdover count not cleared");
endmodule : phs_ctrl
`default_nettype wire

/* File: tb/phs_pll_model.sv */
// behavioural far side: phase detector ticks with commanded error, reference ticks
`timescale 1ns/1ps
`default_nettype none
module phs_pll_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] err1_cmd,
    input wire logic [7:0] err2_cmd,
    output logic loop1_pd_tick,
    output logic loop2_pd_tick,
    output logic [7:0] loop1_phase_err,
    output logic [7:0] loop2_phase_err,
    output logic [1:0] ref_clk_tick
);
    logic [7:0] cyc_reg;
    // cal divide and detector-rate bit live outside this block; ticks model a legal setup
    // wrap at the common multiple of all tick spacings so no two ticks of one stream ever abut
    always_ff @(posedge core_clk) begin
        cyc_reg <= (sys_rst || cyc_reg == 8'h3b) ? 8'h00 : cyc_reg + 8'h01;
    end
    assign loop1_pd_tick = (cyc_reg % 8'h05) == 8'h00;
    assign loop2_pd_tick = (cyc_reg % 8'h03) == 8'h00;
    assign ref_clk_tick = {(cyc_reg % 8'h04) == 8'h02, (cyc_reg % 8'h04) == 8'h00};
    // error is only meaningful at a tick; elsewhere show the inverse so stale use shows
    assign loop1_phase_err = loop1_pd_tick ? err1_cmd : ~err1_cmd;
    assign loop2_phase_err = loop2_pd_tick ? err2_cmd : ~err2_cmd;
endmodule : phs_pll_model
`default_nettype wire

/* File: tb/phs_ctrl_bench.sv */
// self-checking bench for the holdover, lock detect and sync control block
`timescale 1ns/1ps
`default_nettype none
module phs_ctrl_bench;
    localparam logic [9:0] LO = {phs_pkg::DAC_STEP_50MV[8:0], 1'b0};
    localparam logic [9:0] HI = phs_pkg::DAC_FULL - LO;
    localparam logic [9:0] RAIL_VAL [4] = '{LO, LO + 10'h001, HI, HI - 10'h001};
    localparam logic [3:0] RAIL_HIT = 4'h5;
    logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic sync_pin = 1'b0, ref_loss = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [7:0] err1_cmd = 8'h40, err2_cmd = 8'h40, loop1_phase_err, loop2_phase_err;
    logic [9:0] loop1_tune_level = 10'h000, dac_level;
    logic [1:0] ref_sel_pins = 2'b00, ref_clk_tick, ref_sel_sensed, ref_div_tick;
    logic [5:0] pair_in_sync, seen_sync = 6'h00;
    logic loop1_pd_tick, loop2_pd_tick, loop1_lock, loop2_lock;
    logic holdover_active, dac_on, dac_update, clock_switch;
    logic [3:0] gap_cnt [3], gap_last [3];
    logic [2:0] gap_in, gap_out;
    int n_errors = 0, checks_done = 0, i;

    phs_ctrl dut (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .sync_pin(sync_pin),
        .loop1_pd_tick(loop1_pd_tick),
        .loop1_phase_err(loop1_phase_err),
        .loop2_pd_tick(loop2_pd_tick),
        .loop2_phase_err(loop2_phase_err),
        .loop1_tune_level(loop1_tune_level),
        .ref_loss(ref_loss),
        .ref_sel_pins(ref_sel_pins),
        .ref_clk_tick(ref_clk_tick),
        .ref_sel_sensed(ref_sel_sensed),
        .ref_div_tick(ref_div_tick),
        .pair_in_sync(pair_in_sync),
        .loop1_lock(loop1_lock),
        .loop2_lock(loop2_lock),
        .holdover_active(holdover_active),
        .dac_on(dac_on),
        .dac_level(dac_level),
        .dac_update(dac_update),
        .clock_switch(clock_switch)
    );
    phs_pll_model far (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .err1_cmd(err1_cmd),
        .err2_cmd(err2_cmd),
        .loop1_pd_tick(loop1_pd_tick),
        .loop2_pd_tick(loop2_pd_tick),
        .loop1_phase_err(loop1_phase_err),
        .loop2_phase_err(loop2_phase_err),
        .ref_clk_tick(ref_clk_tick)
    );

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // input ticks between two output pulses, for every divided stream
    assign gap_in = {ref_clk_tick, loop1_pd_tick};
    assign gap_out = {ref_div_tick, dac_update};
    always @(posedge core_clk) begin
        seen_sync <= seen_sync | pair_in_sync;
        for (int k = 0; k < 3; k++) begin
            if (gap_out[k]) begin
                gap_last[k] <= gap_cnt[k];
                gap_cnt[k] <= {3'h0, gap_in[k]};
            end else begin
                gap_cnt[k] <= gap_cnt[k] + {3'h0, gap_in[k]};
            end
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    // counts loop1 ticks at the falling edge, ends just after the edge that took the last
    task automatic ticks(input int n);
        for (int c = 0; c < 300 && n > 0; c++) begin
            @(negedge core_clk);
            n -= int'(loop1_pd_tick);
        end
        // a stalled tick stream is a failure, not a silent pass
        if (n > 0) begin
            n_errors++;
            finish_test();
        end
        cyc(1);
    endtask : ticks

    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(phs_pkg::ADDR_STATUS, 16'h0000, "status");
        rd(phs_pkg::ADDR_DAC_MAN, 16'h0200, "dac readback");
        rd(4'h9, 16'h0000, "unmapped");
        wr(phs_pkg::ADDR_STATUS, 16'h003e);
        rd(phs_pkg::ADDR_STATUS, 16'h0000, "status ro");
        // lock counts: four in-window ticks needed for loop1, three for loop2
        wr(phs_pkg::ADDR_LOOP1_LOCK, 16'h0410);
        wr(phs_pkg::ADDR_LOOP2_LOCK, 16'h0310);
        err2_cmd <= 8'h0f;
        err1_cmd <= 8'h02;
        ticks(3);
        chk("loop1 early", 16'h0000, {15'h0, loop1_lock});
        ticks(1);
        cyc(2);
        chk("loop1 lock", 16'h0001, {15'h0, loop1_lock});
        chk("loop2 lock", 16'h0001, {15'h0, loop2_lock});
        rd(phs_pkg::ADDR_STATUS, 16'h0006, "lock status");
        err1_cmd <= 8'h11;
        ticks(1);
        cyc(2);
        chk("loop1 drop", 16'h0000, {15'h0, loop1_lock});
        // sync: pair 0 excluded throughout
        wr(phs_pkg::ADDR_SYNC_CTRL, 16'h0408);
        cyc(3);
        seen_sync = 6'h00;
        sync_pin <= 1'b1;
        cyc(4);
        chk("pin sync", 16'h003e, {10'h0, seen_sync});
        seen_sync = 6'h00;
        wr(phs_pkg::ADDR_SYNC_CTRL, 16'h0409);
        cyc(4);
        chk("invert sync", 16'h003e, {10'h0, seen_sync});
        wr(phs_pkg::ADDR_SYNC_CTRL, 16'h0c09);
        cyc(4);
        seen_sync = 6'h00;
        wr(phs_pkg::ADDR_DAC_DIV, 16'h0003);
        cyc(4);
        chk("no auto sync", 16'h0000, {10'h0, seen_sync});
        wr(phs_pkg::ADDR_LOOP2_LOCK, 16'h0310);
        cyc(4);
        chk("auto sync", 16'h003e, {10'h0, seen_sync});
        wr(phs_pkg::ADDR_SYNC_CTRL, 16'h000b);
        wr(phs_pkg::ADDR_SYNC_CTRL, 16'h000a);
        cyc(30);
        chk("sync held", 16'h003e, {10'h0, pair_in_sync});
        err1_cmd <= 8'h02;
        ticks(5);
        cyc(3);
        chk("sync freed", 16'h0000, {10'h0, pair_in_sync});
        // tracking, dac divider, reference prescalers and pin inversion under policy 3
        loop1_tune_level <= 10'h155;
        ref_sel_pins <= 2'b01;
        wr(phs_pkg::ADDR_REF_CTRL, 16'h0305);
        wr(phs_pkg::ADDR_HOLD_CTRL, 16'h0064);
        cyc(120);
        chk("tracked dac", 16'h0155, {6'h0, dac_level});
        rd(phs_pkg::ADDR_DAC_MAN, 16'h0155, "dac readback");
        chk("dac gap", 16'h0003, {12'h0, gap_last[0]});
        chk("ref0 gap", 16'h0002, {12'h0, gap_last[1]});
        chk("ref1 gap", 16'h0003, {12'h0, gap_last[2]});
        chk("sel sensed", 16'h0002, {14'h0, ref_sel_sensed});
        // automatic holdover; error kept out of window so no exit count builds up early
        wr(phs_pkg::ADDR_HOLD_CTRL, 16'h0300);
        err1_cmd <= 8'h11;
        ref_loss <= 1'b1;
        cyc(10);
        chk("no auto hold", 16'h0000, {15'h0, holdover_active});
        wr(phs_pkg::ADDR_HOLD_CTRL, 16'h0301);
        cyc(3);
        chk("auto hold", 16'h0001, {15'h0, holdover_active});
        ref_loss <= 1'b0;
        err1_cmd <= 8'h02;
        ticks(2);
        chk("hold kept", 16'h0001, {15'h0, holdover_active});
        ticks(2);
        cyc(3);
        chk("hold exit", 16'h0000, {15'h0, holdover_active});
        // forced holdover, manual dac and both rail thresholds at their boundaries
        wr(phs_pkg::ADDR_DAC_TRIP, 16'h0202);
        wr(phs_pkg::ADDR_HOLD_CTRL, 16'h009a);
        cyc(3);
        chk("forced hold", 16'h0001, {15'h0, holdover_active});
        chk("dac on", 16'h0001, {15'h0, dac_on});
        for (i = 0; i < 4; i++) begin
            wr(phs_pkg::ADDR_DAC_MAN, {6'h0, RAIL_VAL[i]});
            cyc(60);
            chk("manual dac", {6'h0, RAIL_VAL[i]}, {6'h0, dac_level});
            chk("rail switch", {15'h0, RAIL_HIT[i]}, {15'h0, clock_switch});
        end
        rd(phs_pkg::ADDR_DAC_MAN, {6'h0, RAIL_VAL[3]}, "dac readback");
        finish_test();
    end
endmodule : phs_ctrl_bench
`default_nettype wire
